// *** common/hpfs_map.svh ***
`ifndef HPFS_MAP_SVH
`define HPFS_MAP_SVH
// pin indices inside the five-line group (port lines 11..15)
`define HPFS_LINE_ELEVEN   0
`define HPFS_LINE_TWELVE   1
`define HPFS_LINE_THIRTEEN 2
`define HPFS_LINE_FOURTEEN 3
`define HPFS_LINE_FIFTEEN  4
`define HPFS_NUM_LINES     5
// polarity reset value: 0 means active low
`define HPFS_POL_RESET     1'h0
// gpio direction reset value: disconnected
`define HPFS_GPIO_RESET    2'h0
`define HPFS_SYNC_STAGES   2
`endif

// *** common/hpfs_pkg.sv ***
package hpfs_pkg;
  typedef enum logic [1:0] {
    HPFS_GPIO_OFF = 2'h0,
    HPFS_GPIO_IN  = 2'h1,
    HPFS_GPIO_OUT = 2'h2
  } hpfs_gpio_dir_e;

  // host bus style as held by the host_port_control bits
  typedef struct packed {
    logic host_function;
    logic double_strobe;
    logic multiplexed;
    logic double_request;
    logic request_open_drain;
  } hpfs_style_s;

  // polarity bits: 1 means active high
  typedef struct packed {
    logic strobe_high;
    logic select_high;
    logic ack_high;
    logic request_high;
  } hpfs_pol_s;

  // active-high qualifiers seen by the inner host logic
  typedef struct packed {
    logic read_strobe;
    logic write_strobe;
    logic single_strobe;
    logic read_write_select;
    logic select;
    logic addr_ten;
    logic ack;
  } hpfs_qual_s;
endpackage

// *** rtl/hpfs_pin_select.sv ***
`timescale 1ns/1ps
`include "hpfs_map.svh"
// Notes on behaviour
// (R1) pin functions follow host_port_control style bits
// (R2) double strobe: line eleven read strobe, line twelve write strobe
// (R3) double strobe: writes qualified by line twelve write strobe
// (R4) single strobe: line twelve data strobe, line eleven read/write select
// (R5) strobe polarity programmable, active low after reset
// (R6) nonmultiplexed: line thirteen chip select, programmable polarity, low
// (R7) multiplexed: line thirteen is host address bit ten
// (R8) single request: line fourteen drives combined request
// (R9) single request: line fifteen is acknowledge input, polarity low
// (R10) double request: line fourteen drives transmit request
// (R11) double request: line fifteen drives receive request
// (R12) request polarity programmable, active low after reset
// (R13) each request output driven or open drain
// (R14) gpio mode: each line input, output or disconnected
// (R15) after reset all lines gpio disconnected
// (R16) host puts address bit ten on line thirteen when multiplexed
// (R17) inputs synchronised then polarity inverted to active high
module hpfs_pin_select
  import hpfs_pkg::*;
#(
  parameter int NUM_LINES   = `HPFS_NUM_LINES,
  parameter int SYNC_STAGES = `HPFS_SYNC_STAGES
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire hpfs_style_s          host_port_control,
  input  wire hpfs_pol_s            polarity,
  input  wire logic [NUM_LINES-1:0] gpio_dir_out,
  input  wire logic [NUM_LINES-1:0] gpio_dir_in,
  input  wire logic [NUM_LINES-1:0] gpio_out_data,
  input  wire logic                 combined_request,
  input  wire logic                 transmit_request,
  input  wire logic                 receive_request,
  input  wire logic [NUM_LINES-1:0] pin_in,
  output logic      [NUM_LINES-1:0] pin_out,
  output logic      [NUM_LINES-1:0] pin_oe,
  output logic      [NUM_LINES-1:0] gpio_in_data,
  output hpfs_qual_s                qual
);

  initial begin
    if (NUM_LINES != `HPFS_NUM_LINES || SYNC_STAGES != `HPFS_SYNC_STAGES)
      $error("hpfs_pin_select: unsupported parameters");
  end

  localparam int L11 = `HPFS_LINE_ELEVEN;
  localparam int L12 = `HPFS_LINE_TWELVE;
  localparam int L13 = `HPFS_LINE_THIRTEEN;
  localparam int L14 = `HPFS_LINE_FOURTEEN;
  localparam int L15 = `HPFS_LINE_FIFTEEN;

  // two-stage synchroniser; stage one is read only by stage two
  logic [NUM_LINES-1:0] sync1_ff, sync2_ff;
  logic [NUM_LINES-1:0] nxt_sync1, nxt_sync2;
  // registered configuration, so style changes land cleanly
  hpfs_style_s          style_ff, nxt_style;
  hpfs_pol_s            pol_ff, nxt_pol;
  hpfs_gpio_dir_e       dir_ff [NUM_LINES];
  hpfs_gpio_dir_e       nxt_dir [NUM_LINES];
  logic [NUM_LINES-1:0] pin_out_ff, nxt_pin_out;
  logic [NUM_LINES-1:0] pin_oe_ff, nxt_pin_oe;
  logic [NUM_LINES-1:0] gin_ff, nxt_gin;
  hpfs_qual_s           qual_ff, nxt_qual;
  logic                 req14, req15;

  always_comb begin
    nxt_sync1 = pin_in;
    nxt_sync2 = sync1_ff;
    nxt_style = host_port_control;
    nxt_pol   = polarity;
    for (int i = 0; i < NUM_LINES; i++) begin
      // (R14) per-line gpio direction
      if (gpio_dir_out[i])
        nxt_dir[i] = HPFS_GPIO_OUT;
      else if (gpio_dir_in[i])
        nxt_dir[i] = HPFS_GPIO_IN;
      else
        nxt_dir[i] = HPFS_GPIO_OFF;
    end
  end

  always_comb begin
    nxt_pin_out = '0;
    nxt_pin_oe  = '0;
    nxt_gin     = '0;
    nxt_qual    = '0;
    // (R12) request polarity inversion
    req14 = (style_ff.double_request ? transmit_request : combined_request)
            ^ ~pol_ff.request_high;
    req15 = receive_request ^ ~pol_ff.request_high;
    // (R1) host function versus gpio
    if (style_ff.host_function) begin
      // (R17) polarity applied after synchroniser
      if (style_ff.double_strobe) begin
        // (R2) separate read and write strobes
        nxt_qual.read_strobe  = sync2_ff[L11] ^ ~pol_ff.strobe_high;
        // (R3) write strobe on line twelve
        nxt_qual.write_strobe = sync2_ff[L12] ^ ~pol_ff.strobe_high;
      end else begin
        // (R4) single strobe plus direction
        // (R5) strobe polarity
        nxt_qual.single_strobe     = sync2_ff[L12] ^ ~pol_ff.strobe_high;
        nxt_qual.read_write_select = sync2_ff[L11];
      end
      if (style_ff.multiplexed) begin
        // (R7) (R16) address bit ten
        nxt_qual.addr_ten = sync2_ff[L13];
      end else begin
        // (R6) chip select polarity
        nxt_qual.select = sync2_ff[L13] ^ ~pol_ff.select_high;
      end
      // (R8) (R10) line fourteen request
      // (R13) open drain only pulls low
      nxt_pin_out[L14] = style_ff.request_open_drain ? 1'h0 : req14;
      nxt_pin_oe[L14]  = style_ff.request_open_drain ? ~req14 : 1'h1;
      if (style_ff.double_request) begin
        // (R11) receive request on line fifteen
        nxt_pin_out[L15] = style_ff.request_open_drain ? 1'h0 : req15;
        nxt_pin_oe[L15]  = style_ff.request_open_drain ? ~req15 : 1'h1;
      end else begin
        // (R9) acknowledge input
        nxt_qual.ack = sync2_ff[L15] ^ ~pol_ff.ack_high;
      end
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        case (dir_ff[i])
          HPFS_GPIO_OUT: begin
            nxt_pin_out[i] = gpio_out_data[i];
            nxt_pin_oe[i]  = 1'h1;
          end
          HPFS_GPIO_IN: begin
            nxt_gin[i] = sync2_ff[i];
          end
          default: begin
            // disconnected: input ignored, pin not driven
            nxt_gin[i] = 1'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_ff   <= '0;
      sync2_ff   <= '0;
      // (R15) reset to gpio disconnected
      style_ff   <= '0;
      // (R5) active low after reset
      pol_ff     <= '0;
      for (int i = 0; i < NUM_LINES; i++)
        dir_ff[i] <= HPFS_GPIO_OFF;
      pin_out_ff <= '0;
      pin_oe_ff  <= '0;
      gin_ff     <= '0;
      qual_ff    <= '0;
    end else begin
      sync1_ff   <= nxt_sync1;
      sync2_ff   <= nxt_sync2;
      style_ff   <= nxt_style;
      pol_ff     <= nxt_pol;
      for (int i = 0; i < NUM_LINES; i++)
        dir_ff[i] <= nxt_dir[i];
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
      gin_ff     <= nxt_gin;
      qual_ff    <= nxt_qual;
    end
  end

  assign pin_out      = pin_out_ff;
  assign pin_oe       = pin_oe_ff;
  assign gpio_in_data = gin_ff;
  assign qual         = qual_ff;

  // (R13) open drain never drives high
  open_drain_low_a: assert property (@(posedge mclk) disable iff (reset)
    $past(style_ff.host_function) && $past(style_ff.request_open_drain)
    |-> !(pin_oe[L14] && pin_out[L14]))
    else $error("open drain request drove high");

  // (R15) gpio off means no drive
  gpio_off_hiz_a: assert property (@(posedge mclk) disable iff (reset)
    !style_ff.host_function && dir_ff[L11] == HPFS_GPIO_OFF
    |=> !pin_oe[L11])
    else $error("disconnected line driven");

  // (R9) ack line not driven in single request mode
  ack_not_driven_a: assert property (@(posedge mclk) disable iff (reset)
    style_ff.host_function && !style_ff.double_request |=> !pin_oe[L15])
    else $error("ack line driven");

  // (R11) receive request driven when push pull
  rx_req_drive_a: assert property (@(posedge mclk) disable iff (reset)
    style_ff.host_function && style_ff.double_request &&
    !style_ff.request_open_drain |=> pin_oe[L15])
    else $error("receive request not driven");

  // (R17) strobe follows pin after sync
  strobe_latency_a: assert property (@(posedge mclk) disable iff (reset)
    style_ff.host_function && !style_ff.double_strobe &&
    $stable(pol_ff) |=> qual.single_strobe ==
    ($past(sync2_ff[L12]) ^ ~$past(pol_ff.strobe_high)))
    else $error("strobe qualifier wrong");

  // (R6) select qualifier absent when multiplexed
  select_muxed_a: assert property (@(posedge mclk) disable iff (reset)
    style_ff.multiplexed |=> !qual.select)
    else $error("select seen in multiplexed mode");

  // (R8) push pull request level
  req_level_a: assert property (@(posedge mclk) disable iff (reset)
    style_ff.host_function && !style_ff.request_open_drain
    |=> pin_out[L14] == $past(req14))
    else $error("request level wrong");

  // (R1) gpio input gated off in host mode
  host_gin_zero_a: assert property (@(posedge mclk) disable iff (reset)
    style_ff.host_function |=> gpio_in_data == '0)
    else $error("gpio input leaked in host mode");
endmodule

// *** tb/hpfs_host_model.sv ***
`timescale 1ns/1ps
module hpfs_host_model (
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] host_val,
  input  wire logic [4:0] host_oe,
  output logic      [4:0] pin_in
);
  // device drive wins over the host value
  // released lines go to the pull-up, never the last value
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (host_oe[i])
        pin_in[i] = host_val[i];
      else
        pin_in[i] = 1'h1;
    end
  end
endmodule

// *** tb/hpfs_pin_select_bench.sv ***
`timescale 1ns/1ps
module hpfs_pin_select_bench;
  import hpfs_pkg::*;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  hpfs_style_s host_port_control = 5'h00;
  hpfs_pol_s   polarity = 4'h0;
  logic [4:0]  gpio_dir_out = 5'h00;
  logic [4:0]  gpio_dir_in = 5'h00;
  logic [4:0]  gpio_out_data = 5'h00;
  logic        combined_request = 1'h0;
  logic        transmit_request = 1'h0;
  logic        receive_request = 1'h0;
  logic [4:0]  host_val = 5'h00;
  logic [4:0]  host_oe = 5'h1f;
  logic [4:0]  pin_in;
  logic [4:0]  pin_out;
  logic [4:0]  pin_oe;
  logic [4:0]  gpio_in_data;
  hpfs_qual_s  qual;
  int          miscompares = 0;
  int          total_checks = 0;

  always #50 mclk = ~mclk;

  hpfs_pin_select i_hpfs_pin_select (.mclk, .reset, .host_port_control,
    .polarity, .gpio_dir_out, .gpio_dir_in, .gpio_out_data,
    .combined_request, .transmit_request, .receive_request, .pin_in,
    .pin_out, .pin_oe, .gpio_in_data, .qual);
  hpfs_host_model i_hpfs_host_model (.pin_out, .pin_oe, .host_val,
    .host_oe, .pin_in);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // inputs settle through sync and output registers
  task automatic setup(input logic [4:0] s, input logic [3:0] p,
                       input logic [4:0] hv);
    host_port_control = s;
    polarity = p;
    host_val = hv;
    step(5);
  endtask

  task automatic t_reset();
    step(5);
    chk(pin_oe, 8'h00);
    chk(qual, 8'h00);
  endtask

  task automatic t_dstrobe();
    host_oe = 5'h17;
    setup(5'h18, 4'h0, 5'h02);
    chk(qual, 8'h45);
    setup(5'h18, 4'ha, 5'h02);
    chk(qual, 8'h24);
  endtask

  task automatic t_sstrobe();
    // address bit ten on line thirteen
    setup(5'h14, 4'h0, 5'h15);
    chk(qual, 8'h1a);
  endtask

  task automatic t_req();
    combined_request = 1'h1;
    setup(5'h18, 4'h0, 5'h02);
    chk({pin_oe[3], pin_out[3]}, 8'h02);
    setup(5'h18, 4'h1, 5'h02);
    chk({pin_oe[3], pin_out[3]}, 8'h03);
    host_oe = 5'h07;
    transmit_request = 1'h1;
    setup(5'h1a, 4'h0, 5'h02);
    chk({pin_oe[4:3], pin_out[4:3]}, 8'h0e);
    setup(5'h1b, 4'h0, 5'h02);
    chk({pin_oe[4:3], pin_out[4:3]}, 8'h04);
  endtask

  task automatic t_gpio();
    gpio_dir_out = 5'h05;
    gpio_dir_in = 5'h0a;
    gpio_out_data = 5'h1f;
    host_oe = 5'h1a;
    setup(5'h00, 4'h0, 5'h1a);
    chk(pin_oe, 8'h05);
    chk(pin_out & pin_oe, 8'h05);
    chk(gpio_in_data, 8'h0a);
  endtask

  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    step(3);
    reset = 1'h0;
    t_reset();
    t_dstrobe();
    t_sstrobe();
    t_req();
    t_gpio();
    stop_test();
  end

  // run needs about 48 cycles
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
endmodule
